// file: shared/rpf_pkg.sv
// constants and carrier types for the per-port filter status and interrupt enable slice
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package rpf_pkg;
  localparam int          NUM_PORTS = 4;
  localparam int          PORT_W    = 2;
  localparam int          DLY_W     = 6;
  localparam int          NUM_COND  = 9;

  // register addresses
  localparam logic [7:0] ADDR_PORT_SEL   = 8'h4c;
  localparam logic [7:0] ADDR_FILT_STS_A = 8'hd6;
  localparam logic [7:0] ADDR_FILT_STS_B = 8'hd7;
  localparam logic [7:0] ADDR_IRQ_EN_HI  = 8'hd8;
  localparam logic [7:0] ADDR_IRQ_EN_LO  = 8'hd9;
  localparam logic [7:0] ADDR_STS_FIRST  = 8'hda;
  localparam logic [7:0] ADDR_STS_SECOND = 8'hdb;

  // field positions
  localparam int BIT_LIMIT   = 7;
  localparam int BIT_SETTLED = 6;
  localparam int BIT_FAULT   = 6;
  localparam int BIT_ENC     = 2;
  localparam int BIT_SEQ     = 1;
  localparam int BIT_CRC     = 0;

  // writable masks; everything else is reserved
  localparam logic [7:0] MASK_EN_HI = 8'h07;
  localparam logic [7:0] MASK_EN_LO = 8'h77;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [NUM_COND-1:0] RST_COND = 9'h000;

  // condition vector order: {enc, seq, crc, len, cnt, buf, par, pass, lock}
  typedef struct packed {
    logic link_encoding_fault;
    logic ctrl_channel_sequence_fault;
    logic ctrl_channel_checksum_fault;
    logic line_length_changed;
    logic line_count_changed;
    logic rx_buffer_overflow;
    logic link_parity_fault;
    logic port_valid_changed;
    logic lock_changed;
  } rpf_cond_t;

  typedef struct packed {
    logic             limit_hit;
    logic             settled;
    logic             measure_invalid;
    logic [DLY_W-1:0] clock_delay;
    logic [DLY_W-1:0] data_delay;
  } rpf_filter_t;

  // conditions cleared by a read of the first status register (lock, pass, parity, seq, crc)
  localparam logic [NUM_COND-1:0] COND_IN_FIRST  = 9'h0c7;
  // conditions cleared by a read of the second status register (enc, len, cnt, buf)
  localparam logic [NUM_COND-1:0] COND_IN_SECOND = 9'h138;
endpackage

// file: src/rpf_port.sv
// one receive port copy: filter status flags, interrupt enables and pending conditions
`timescale 1ns/1ps
module rpf_port (
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst,
  input  wire rpf_pkg::rpf_filter_t i_filter,
  input  wire rpf_pkg::rpf_cond_t  i_cond,
  input  wire logic                i_rd_a,
  input  wire logic                i_rd_b,
  input  wire logic                i_rd_first,
  input  wire logic                i_rd_second,
  input  wire logic                i_wr_hi,
  input  wire logic                i_wr_lo,
  input  wire logic [7:0]          i_wdata,
  output logic [7:0]               o_sts_a,
  output logic [7:0]               o_sts_b,
  output logic [7:0]               o_en_hi,
  output logic [7:0]               o_en_lo,
  output logic [rpf_pkg::NUM_COND-1:0] o_pending,
  output logic                     o_irq
);
  logic                            limit_flag;
  logic                            settled_flag;
  logic                            fault_flag;
  logic [rpf_pkg::NUM_COND-1:0]    enables;
  logic [rpf_pkg::NUM_COND-1:0]    cond_vec;
  logic [rpf_pkg::NUM_COND-1:0]    clr_vec;

  assign cond_vec = i_cond;
  assign clr_vec  = ({rpf_pkg::NUM_COND{i_rd_first}} & rpf_pkg::COND_IN_FIRST)
                  | ({rpf_pkg::NUM_COND{i_rd_second}} & rpf_pkg::COND_IN_SECOND);

  // ----------------------------------------------------------------------------
  // filter status flags
  // ----------------------------------------------------------------------------
  // sticky limit flag, set beats read clear
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      limit_flag <= 1'b0;
    end else if (i_filter.limit_hit) begin
      limit_flag <= 1'b1;
    end else if (i_rd_a) begin
      limit_flag <= 1'b0;
    end
  end

  // latch low, read reloads live value
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      settled_flag <= 1'b0;
    end else if (!i_filter.settled) begin
      settled_flag <= 1'b0;
    end else if (i_rd_a) begin
      settled_flag <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      fault_flag <= 1'b0;
    end else if (i_filter.measure_invalid) begin
      fault_flag <= 1'b1;
    end else if (i_rd_b) begin
      fault_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // enables and pending conditions
  // ----------------------------------------------------------------------------
  // enables reset to zero; reserved bits masked off
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      enables <= rpf_pkg::RST_COND;
    end else begin
      if (i_wr_hi) begin
        enables[8:6] <= i_wdata[2:0];
      end
      if (i_wr_lo) begin
        enables[5:0] <= {i_wdata[6:4], i_wdata[2:0]};
      end
    end
  end

  // read of the register whose clear group holds the bit clears, new event wins
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_pending <= rpf_pkg::RST_COND;
    end else begin
      o_pending <= (o_pending & ~clr_vec) | cond_vec;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(((o_pending & ~clr_vec) | cond_vec) & enables);
    end
  end

  // live delay codes; reserved read zero
  assign o_sts_a = {limit_flag, settled_flag, i_filter.clock_delay};
  assign o_sts_b = {1'b0, fault_flag, i_filter.data_delay};
  assign o_en_hi = {5'h00, enables[8:6]};
  assign o_en_lo = {1'b0, enables[5:3], 1'b0, enables[2:0]};
endmodule

// file: src/rpf_hub.sv
// top: port select and register read/write routing to the per-port copies
`timescale 1ns/1ps
module rpf_hub (
  input  wire logic                                    i_ref_clk,
  input  wire logic                                    i_rst,
  input  wire logic                                    i_rd,
  input  wire logic                                    i_wr,
  input  wire logic [7:0]                              i_addr,
  input  wire logic [7:0]                              i_wdata,
  input  wire rpf_pkg::rpf_filter_t [rpf_pkg::NUM_PORTS-1:0] i_filter,
  input  wire rpf_pkg::rpf_cond_t   [rpf_pkg::NUM_PORTS-1:0] i_cond,
  output logic [7:0]                                   o_rdata,
  output logic                                         o_rvalid,
  output logic [rpf_pkg::NUM_PORTS-1:0]                o_port_irq
);
  logic [rpf_pkg::PORT_W-1:0]    port_sel;
  logic [7:0]                    sts_a   [rpf_pkg::NUM_PORTS];
  logic [7:0]                    sts_b   [rpf_pkg::NUM_PORTS];
  logic [7:0]                    en_hi   [rpf_pkg::NUM_PORTS];
  logic [7:0]                    en_lo   [rpf_pkg::NUM_PORTS];
  logic [rpf_pkg::NUM_COND-1:0]  pend    [rpf_pkg::NUM_PORTS];
  logic [rpf_pkg::NUM_PORTS-1:0] irq;
  logic [7:0]                    next_rdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  // ----------------------------------------------------------------------------
  // port select
  // ----------------------------------------------------------------------------
  // selected copy receives accesses
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      port_sel <= '0;
    end else if (i_wr && hit(i_addr, rpf_pkg::ADDR_PORT_SEL)) begin
      port_sel <= i_wdata[rpf_pkg::PORT_W-1:0];
    end
  end

  for (genvar p = 0; p < rpf_pkg::NUM_PORTS; p++) begin : g_port
    logic sel;
    assign sel = (int'(port_sel) == p);
    rpf_port u_port (
      .i_ref_clk   (i_ref_clk),
      .i_rst       (i_rst),
      .i_filter    (i_filter[p]),
      .i_cond      (i_cond[p]),
      .i_rd_a      (sel && i_rd && hit(i_addr, rpf_pkg::ADDR_FILT_STS_A)),
      .i_rd_b      (sel && i_rd && hit(i_addr, rpf_pkg::ADDR_FILT_STS_B)),
      .i_rd_first  (sel && i_rd && hit(i_addr, rpf_pkg::ADDR_STS_FIRST)),
      .i_rd_second (sel && i_rd && hit(i_addr, rpf_pkg::ADDR_STS_SECOND)),
      .i_wr_hi     (sel && i_wr && hit(i_addr, rpf_pkg::ADDR_IRQ_EN_HI)),
      .i_wr_lo     (sel && i_wr && hit(i_addr, rpf_pkg::ADDR_IRQ_EN_LO)),
      .i_wdata     (i_wdata),
      .o_sts_a     (sts_a[p]),
      .o_sts_b     (sts_b[p]),
      .o_en_hi     (en_hi[p]),
      .o_en_lo     (en_lo[p]),
      .o_pending   (pend[p]),
      .o_irq       (irq[p])
    );
  end

  // ----------------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------------
  // pending bits shown in the interrupt status layout; unmapped reads give zero
  always_comb begin
    next_rdata = rpf_pkg::RST_BYTE;
    unique case (i_addr)
      rpf_pkg::ADDR_PORT_SEL:   next_rdata = {6'h00, port_sel};
      rpf_pkg::ADDR_FILT_STS_A: next_rdata = sts_a[port_sel];
      rpf_pkg::ADDR_FILT_STS_B: next_rdata = sts_b[port_sel];
      rpf_pkg::ADDR_IRQ_EN_HI:  next_rdata = en_hi[port_sel];
      rpf_pkg::ADDR_IRQ_EN_LO:  next_rdata = en_lo[port_sel];
      rpf_pkg::ADDR_STS_FIRST:  next_rdata = {5'h00, pend[port_sel][8:6]};
      rpf_pkg::ADDR_STS_SECOND:
        next_rdata = {1'b0, pend[port_sel][5:3], 1'b0, pend[port_sel][2:0]};
      default:                  next_rdata = rpf_pkg::RST_BYTE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rdata  <= rpf_pkg::RST_BYTE;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd;
      if (i_rd) begin
        o_rdata <= next_rdata;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_port_irq <= '0;
    end else begin
      o_port_irq <= irq;
    end
  end
endmodule

// file: testbench/rpf_hub_assertions.sv
// checker for read answers, reserved read-back and interrupt causes
`timescale 1ns/1ps
module rpf_hub_assertions (
  input  wire logic                                          i_ref_clk,
  input  wire logic                                          i_rst,
  input  wire logic                                          i_rd,
  input  wire logic                                          i_wr,
  input  wire logic [7:0]                                    i_addr,
  input  wire rpf_pkg::rpf_cond_t [rpf_pkg::NUM_PORTS-1:0]   i_cond,
  input  wire logic [7:0]                                    o_rdata,
  input  wire logic                                          o_rvalid,
  input  wire logic [rpf_pkg::NUM_PORTS-1:0]                 o_port_irq
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic mapped;
  assign mapped = (i_addr == 8'h4c) || (i_addr >= 8'hd6 && i_addr <= 8'hdb);
  property p_rd_answer; i_rd |=> o_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_no_stray; !i_rd |=> !o_rvalid; endproperty
  a_no_stray: assert property (p_no_stray) else $error("answer without read");
  property p_unmapped; i_rd && !mapped |=> o_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_sts_b_rsvd; i_rd && i_addr == 8'hd7 |=> !o_rdata[7]; endproperty
  a_sts_b_rsvd: assert property (p_sts_b_rsvd) else $error("d7 bit 7 set");
  property p_en_hi_rsvd; i_rd && i_addr == 8'hd8 |=> o_rdata[7:3] == 5'h00; endproperty
  a_en_hi_rsvd: assert property (p_en_hi_rsvd) else $error("d8 reserved set");
  property p_en_lo_rsvd; i_rd && i_addr == 8'hd9 |=> (o_rdata & 8'h88) == 8'h00; endproperty
  a_en_lo_rsvd: assert property (p_en_lo_rsvd) else $error("d9 reserved set");
  property p_irq_reset; $past(i_rst) |-> o_port_irq == '0; endproperty
  a_irq_reset: assert property (p_irq_reset) else $error("irq after reset");
  // the request is registered twice: an event shows two edges later, an enable write three
  property p_irq_rise;
    (o_port_irq & ~$past(o_port_irq)) != '0 |-> $past(|i_cond, 2) || $past(i_wr, 3);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_irq_fall;
    (~o_port_irq & $past(o_port_irq)) != '0 |-> $past(i_rd, 2) || $past(i_wr, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without access");
  cover property (i_rd && i_addr == 8'hd6);
  cover property ($rose(|o_port_irq));
  cover property ($fell(|o_port_irq));
endmodule
bind rpf_hub rpf_hub_assertions u_rpf_hub_assertions (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_rd(i_rd), .i_wr(i_wr), .i_addr(i_addr), .i_cond(i_cond), .o_rdata(o_rdata),
  .o_rvalid(o_rvalid), .o_port_irq(o_port_irq));

// file: testbench/rpf_hub_tb.sv
// self-checking bench for the per-port filter status and interrupt enable slice
`timescale 1ns/1ps
module rpf_hub_tb;
  logic                                          i_ref_clk = 1'b0;
  logic                                          i_rst = 1'b1;
  logic                                          i_rd = 1'b0;
  logic                                          i_wr = 1'b0;
  logic [7:0]                                    i_addr = 8'h00;
  logic [7:0]                                    i_wdata = 8'h00;
  rpf_pkg::rpf_filter_t [rpf_pkg::NUM_PORTS-1:0] i_filter;
  rpf_pkg::rpf_cond_t [rpf_pkg::NUM_PORTS-1:0]   i_cond;
  logic [7:0]                                    o_rdata;
  logic                                          o_rvalid;
  logic [rpf_pkg::NUM_PORTS-1:0]                 o_port_irq;
  logic [7:0]                                    exp_q[$];
  logic [31:0]                                   seed = 32'h206b;
  logic [5:0]                                    cd[4];
  logic [5:0]                                    dd[4];
  logic [8:0]                                    c;
  logic [7:0]                                    hi;
  logic [7:0]                                    lo;
  // conditions cleared by reading 0xda: lock, pass, parity, seq, crc
  localparam logic [8:0]                         GRP_FIRST = 9'h0c7;
  int                                            n_mismatch = 0;
  int                                            n_checks = 0;
  always #2.5 i_ref_clk = ~i_ref_clk;
  rpf_hub u_rpf_hub (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_rd(i_rd), .i_wr(i_wr),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_filter(i_filter), .i_cond(i_cond),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_port_irq(o_port_irq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task cmp_data(input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected read data: expected %h, seen %h", e, g);
    end
  endtask
  task cmp_irq(input logic [3:0] e);
    n_checks++;
    if (o_port_irq !== e) begin
      n_mismatch++;
      $display("unexpected port irq: expected %h, seen %h", e, o_port_irq);
    end
  endtask
  // one idle cycle follows each access so strobes never toggle twice in a step
  task acc(input logic r, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    i_rd = r;
    i_wr = ~r;
    i_addr = a;
    i_wdata = d;
    @(negedge i_ref_clk);
    i_rd = 1'b0;
    i_wr = 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b0, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(1'b1, a, 8'h00);
  endtask
  // outputs are registered, so the falling edge sees them settled
  always @(negedge i_ref_clk) begin
    if (o_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("unexpected read answer: expected none, seen %h", o_rdata);
      end else begin
        cmp_data(exp_q.pop_front(), o_rdata);
      end
    end
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    i_filter = '0;
    i_cond = '0;
    for (int p = 0; p < 4; p++) begin
      seed = lfsr(seed);
      cd[p] = seed[5:0];
      dd[p] = seed[13:8];
      i_filter[p].clock_delay = cd[p];
      i_filter[p].data_delay = dd[p];
      i_filter[p].settled = 1'b1;
    end
    repeat (20) @(negedge i_ref_clk);
    i_rst = 1'b0;
    for (int p = 0; p < 4; p++) begin
      wr(8'h4c, 8'(p));
      rd(8'hd6, {2'b00, cd[p]});
      rd(8'hd6, {2'b01, cd[p]});
      rd(8'hd7, {2'b00, dd[p]});
      rd(8'hd8, 8'h00);
      rd(8'hd9, 8'h00);
    end
    wr(8'hd8, 8'hff);
    wr(8'hd9, 8'hff);
    wr(8'hd6, seed[23:16]);
    rd(8'hd8, 8'h07);
    rd(8'hd9, 8'h77);
    rd(8'hd6, {2'b01, cd[3]});
    rd(8'hd0, 8'h00);
    @(negedge i_ref_clk);
    i_filter[3].limit_hit = 1'b1;
    i_filter[3].measure_invalid = 1'b1;
    i_filter[3].settled = 1'b0;
    @(negedge i_ref_clk);
    i_filter[3].limit_hit = 1'b0;
    i_filter[3].measure_invalid = 1'b0;
    i_filter[3].settled = 1'b1;
    rd(8'hd6, {2'b10, cd[3]});
    rd(8'hd6, {2'b01, cd[3]});
    rd(8'hd7, {2'b01, dd[3]});
    seed = lfsr(seed);
    i_filter[3].data_delay = seed[5:0];
    rd(8'hd7, {2'b00, seed[5:0]});
    wr(8'h4c, 8'h00);
    rd(8'hd8, 8'h00);
    wr(8'h4c, 8'h02);
    // pending latches with enables clear but the request stays low
    @(negedge i_ref_clk);
    i_cond[2] = rpf_pkg::rpf_cond_t'(9'h1ff);
    @(negedge i_ref_clk);
    i_cond[2] = '0;
    @(negedge i_ref_clk);
    cmp_irq(4'h0);
    rd(8'hda, 8'h07);
    rd(8'hdb, 8'h70);
    for (int i = 0; i < 9; i++) begin
      c = 9'h001 << i;
      hi = {5'h00, c[8:6]};
      lo = {1'b0, c[5:3], 1'b0, c[2:0]};
      wr(8'hd8, hi);
      wr(8'hd9, lo);
      cmp_irq(4'h0);
      i_cond[2] = rpf_pkg::rpf_cond_t'(c);
      @(negedge i_ref_clk);
      i_cond[2] = '0;
      @(negedge i_ref_clk);
      cmp_irq(4'h4);
      // the register that does not clear this bit is read first and must leave the request up
      if (GRP_FIRST[i]) rd(8'hdb, lo);
      else rd(8'hda, hi);
      @(negedge i_ref_clk);
      cmp_irq(4'h4);
      if (GRP_FIRST[i]) rd(8'hda, hi);
      else rd(8'hdb, lo);
      @(negedge i_ref_clk);
      cmp_irq(4'h0);
    end
    for (int k = 0; k < 10 && exp_q.size() != 0; k++) @(negedge i_ref_clk);
    if (exp_q.size() != 0) n_mismatch++;
    tally_and_finish();
  end
endmodule
